/* rtl/rcm_pkg.sv */
package rcm_pkg;

  // ****************************************
  // pci command codes
  // ****************************************
  localparam logic [3:0] CMD_MEM_RD  = 4'h6;
  localparam logic [3:0] CMD_MEM_WR  = 4'h7;
  localparam logic [3:0] CMD_MEM_RDM = 4'hC;
  localparam logic [3:0] CMD_MEM_RDL = 4'hE;
  localparam logic [3:0] CMD_MEM_WRI = 4'hF;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] OFS_PORT_OPT = 8'h74;
  localparam logic [7:0] OFS_STATUS   = 8'h90;
  localparam logic [7:0] OFS_MASK     = 8'h94;

  localparam logic [15:0] OPT_RESET = 16'h0C6A;
  localparam logic [15:0] OPT_WMASK = 16'h0FFE;

  localparam int OPT_P_RD_ALIAS = 1;
  localparam int OPT_P_WR_ALIAS = 2;
  localparam int OPT_S_RD_ALIAS = 3;
  localparam int OPT_S_WR_ALIAS = 4;
  localparam int OPT_P_LM_ALIAS = 5;
  localparam int OPT_S_LM_ALIAS = 6;
  localparam int OPT_P_WRI_DISC = 7;

  localparam int STS_DT_TMO = 23;
  localparam logic [31:0] STS_WMASK = 32'h0080_0000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic       valid;
    logic [3:0] retry_cmd;
    logic [3:0] queued_cmd;
    logic       addr_hit;
  } rcm_cmp_s;

  typedef struct packed {
    logic done;
    logic retry;
  } rcm_rsp_s;

endpackage

/* rtl/rcm_match_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none

// Function
// RQ1 - timeout sets sticky status bit 23 and serr; w1c; reset clears
// RQ2 - option bit 0 reserved, ignored, reads zero
// RQ3 - bit 1: primary line/multiple retry matches plain read; reset 1
// RQ4 - bit 2: primary write-invalidate retry matches plain write; reset 0
// RQ5 - bit 3: secondary line/multiple retry matches plain read; reset 1
// RQ6 - bit 4: secondary write-invalidate retry matches plain write; reset 0
// RQ7 - bit 5: primary read-line and read-multiple alias; reset 1
// RQ8 - bit 6: secondary read-line and read-multiple alias; reset 1
// RQ9 - bit 7: 0 forwards primary write-invalidate as write, 1 disconnects
// RQ10 - compare each retry with selected rule; complete on match, else retry
module rcm_match_ctrl (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  input  wire rcm_pkg::rcm_cmp_s pri_cmp,
  input  wire rcm_pkg::rcm_cmp_s sec_cmp,
  output rcm_pkg::rcm_rsp_s     pri_rsp,
  output rcm_pkg::rcm_rsp_s     sec_rsp,
  input  wire logic             master_timeout,
  input  wire logic [3:0]       pri_fwd_in_cmd,
  output logic [3:0]            pri_fwd_out_cmd,
  output logic                  pri_wri_disconnect,
  output logic                  primary_system_error_n,
  output logic                  irq
);

  // ****************************************
  // matching
  // ****************************************
  function automatic logic cmd_match(
    input logic [3:0] inc,
    input logic [3:0] que,
    input logic       rd_alias,
    input logic       wr_alias,
    input logic       lm_alias
  );
    logic inc_lm;
    logic que_lm;
    inc_lm = (inc == rcm_pkg::CMD_MEM_RDL) ||
             (inc == rcm_pkg::CMD_MEM_RDM);
    que_lm = (que == rcm_pkg::CMD_MEM_RDL) ||
             (que == rcm_pkg::CMD_MEM_RDM);
    cmd_match = (inc == que) ||
      (rd_alias && que == rcm_pkg::CMD_MEM_RD && inc_lm) ||
      (wr_alias && que == rcm_pkg::CMD_MEM_WR &&
       inc == rcm_pkg::CMD_MEM_WRI) ||
      (lm_alias && inc_lm && que_lm);
  endfunction

  function automatic logic [7:0] word_ofs(input logic [7:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction

  logic [15:0] port_opt_reg;
  logic [31:0] status_reg;
  logic [31:0] mask_reg;
  logic [7:0]  aw_addr_reg;
  logic        aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        w_have_reg;
  logic        wr_go;
  logic [31:0] wr_bits;
  logic [31:0] rd_next;
  logic        rd_hit_next;

  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_bits[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8]
                                        : 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pri_rsp <= '0;
    end else begin
      pri_rsp.done  <= pri_cmp.valid && pri_cmp.addr_hit && // RQ10
        cmd_match(pri_cmp.retry_cmd, pri_cmp.queued_cmd,
                  port_opt_reg[rcm_pkg::OPT_P_RD_ALIAS],  // RQ3
                  port_opt_reg[rcm_pkg::OPT_P_WR_ALIAS],  // RQ4
                  port_opt_reg[rcm_pkg::OPT_P_LM_ALIAS]); // RQ7
      pri_rsp.retry <= pri_cmp.valid && !(pri_cmp.addr_hit && // RQ10
        cmd_match(pri_cmp.retry_cmd, pri_cmp.queued_cmd,
                  port_opt_reg[rcm_pkg::OPT_P_RD_ALIAS],
                  port_opt_reg[rcm_pkg::OPT_P_WR_ALIAS],
                  port_opt_reg[rcm_pkg::OPT_P_LM_ALIAS]));
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sec_rsp <= '0;
    end else begin
      sec_rsp.done  <= sec_cmp.valid && sec_cmp.addr_hit && // RQ10
        cmd_match(sec_cmp.retry_cmd, sec_cmp.queued_cmd,
                  port_opt_reg[rcm_pkg::OPT_S_RD_ALIAS],  // RQ5
                  port_opt_reg[rcm_pkg::OPT_S_WR_ALIAS],  // RQ6
                  port_opt_reg[rcm_pkg::OPT_S_LM_ALIAS]); // RQ8
      sec_rsp.retry <= sec_cmp.valid && !(sec_cmp.addr_hit && // RQ10
        cmd_match(sec_cmp.retry_cmd, sec_cmp.queued_cmd,
                  port_opt_reg[rcm_pkg::OPT_S_RD_ALIAS],
                  port_opt_reg[rcm_pkg::OPT_S_WR_ALIAS],
                  port_opt_reg[rcm_pkg::OPT_S_LM_ALIAS]));
    end
  end

  // ****************************************
  // primary write-invalidate forwarding
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      pri_fwd_out_cmd    <= 4'h0;
      pri_wri_disconnect <= 1'b0;
    end else begin
      pri_wri_disconnect <= port_opt_reg[rcm_pkg::OPT_P_WRI_DISC]; // RQ9
      if (!port_opt_reg[rcm_pkg::OPT_P_WRI_DISC] &&
          pri_fwd_in_cmd == rcm_pkg::CMD_MEM_WRI) begin
        pri_fwd_out_cmd <= rcm_pkg::CMD_MEM_WR; // RQ9
      end else begin
        pri_fwd_out_cmd <= pri_fwd_in_cmd;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      port_opt_reg <= rcm_pkg::OPT_RESET; // RQ3
    end else if (wr_go &&
                 word_ofs(aw_addr_reg) == rcm_pkg::OFS_PORT_OPT) begin
      // bit 0 and the top nibble never take a write
      port_opt_reg <= (port_opt_reg & ~rcm_pkg::OPT_WMASK) | // RQ2
                      (wr_bits[15:0] & rcm_pkg::OPT_WMASK);
    end
  end

  // a timeout in the same cycle as the clearing write keeps the flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_reg <= 32'h0000_0000; // RQ1
    end else begin
      if (wr_go && word_ofs(aw_addr_reg) == rcm_pkg::OFS_STATUS) begin
        status_reg <= status_reg & ~(wr_bits & rcm_pkg::STS_WMASK);
      end
      if (master_timeout) begin
        status_reg[rcm_pkg::STS_DT_TMO] <= 1'b1; // RQ1
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_reg <= 32'h0000_0000;
    end else if (wr_go &&
                 word_ofs(aw_addr_reg) == rcm_pkg::OFS_MASK) begin
      mask_reg <= wr_bits & rcm_pkg::STS_WMASK;
    end
  end

  // serr follows the flag one cycle later, as does irq
  always_ff @(posedge mclk) begin
    if (reset) begin
      primary_system_error_n <= 1'b1;
      irq                    <= 1'b0;
    end else begin
      primary_system_error_n <= !status_reg[rcm_pkg::STS_DT_TMO]; // RQ1
      irq                    <= |(status_reg & mask_reg);
    end
  end

  // ****************************************
  // axi4-lite write channel
  // ****************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      aw_have_reg   <= 1'b0;
      aw_addr_reg   <= 8'h00;
    end else begin
      s_axi_awready <= s_axi_awvalid && !s_axi_awready &&
                       !aw_have_reg && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_wready <= 1'b0;
      w_have_reg   <= 1'b0;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
    end else begin
      s_axi_wready <= s_axi_wvalid && !s_axi_wready &&
                      !w_have_reg && !s_axi_bvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= rcm_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      case (word_ofs(aw_addr_reg))
        rcm_pkg::OFS_PORT_OPT,
        rcm_pkg::OFS_STATUS,
        rcm_pkg::OFS_MASK: s_axi_bresp <= rcm_pkg::RESP_OKAY;
        default:           s_axi_bresp <= rcm_pkg::RESP_DECERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // axi4-lite read channel
  // ****************************************
  always_comb begin
    rd_hit_next = 1'b1;
    rd_next     = 32'h0000_0000;
    case (word_ofs(s_axi_araddr))
      rcm_pkg::OFS_PORT_OPT: rd_next = {16'h0000, port_opt_reg}; // RQ2
      rcm_pkg::OFS_STATUS:   rd_next = status_reg;
      rcm_pkg::OFS_MASK:     rd_next = mask_reg;
      default:               rd_hit_next = 1'b0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= rcm_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_next;
        s_axi_rresp  <= rd_hit_next ? rcm_pkg::RESP_OKAY
                                    : rcm_pkg::RESP_DECERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_tmo;
    master_timeout;
  endsequence

  sequence s_serr_after;
    ##2 !primary_system_error_n;
  endsequence

  property p_tmo_serr;
    @(posedge mclk) disable iff (reset) s_tmo |-> s_serr_after;
  endproperty
  a_tmo_serr: assert property (p_tmo_serr) // RQ1
    else $error("timeout did not assert system error");

  property p_flag_sticky;
    @(posedge mclk) disable iff (reset)
      status_reg[rcm_pkg::STS_DT_TMO] && !wr_go
      |=> status_reg[rcm_pkg::STS_DT_TMO];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) // RQ1
    else $error("timeout flag dropped without a write");

  property p_opt_bit0;
    @(posedge mclk) disable iff (reset) !port_opt_reg[0];
  endproperty
  a_opt_bit0: assert property (p_opt_bit0) // RQ2
    else $error("reserved option bit became set");

  property p_pri_rd_alias;
    @(posedge mclk) disable iff (reset)
      pri_cmp.valid && pri_cmp.addr_hit &&
      pri_cmp.queued_cmd == rcm_pkg::CMD_MEM_RD &&
      pri_cmp.retry_cmd == rcm_pkg::CMD_MEM_RDL
      |=> pri_rsp.done == $past(port_opt_reg[rcm_pkg::OPT_P_RD_ALIAS]);
  endproperty
  a_pri_rd_alias: assert property (p_pri_rd_alias) // RQ3
    else $error("primary read alias decision wrong");

  property p_pri_wr_alias;
    @(posedge mclk) disable iff (reset)
      pri_cmp.valid && pri_cmp.addr_hit &&
      pri_cmp.queued_cmd == rcm_pkg::CMD_MEM_WR &&
      pri_cmp.retry_cmd == rcm_pkg::CMD_MEM_WRI
      |=> pri_rsp.done == $past(port_opt_reg[rcm_pkg::OPT_P_WR_ALIAS]);
  endproperty
  a_pri_wr_alias: assert property (p_pri_wr_alias) // RQ4
    else $error("primary write alias decision wrong");

  property p_sec_rd_alias;
    @(posedge mclk) disable iff (reset)
      sec_cmp.valid && sec_cmp.addr_hit &&
      sec_cmp.queued_cmd == rcm_pkg::CMD_MEM_RD &&
      sec_cmp.retry_cmd == rcm_pkg::CMD_MEM_RDM
      |=> sec_rsp.done == $past(port_opt_reg[rcm_pkg::OPT_S_RD_ALIAS]);
  endproperty
  a_sec_rd_alias: assert property (p_sec_rd_alias) // RQ5
    else $error("secondary read alias decision wrong");

  property p_sec_wr_alias;
    @(posedge mclk) disable iff (reset)
      sec_cmp.valid && sec_cmp.addr_hit &&
      sec_cmp.queued_cmd == rcm_pkg::CMD_MEM_WR &&
      sec_cmp.retry_cmd == rcm_pkg::CMD_MEM_WRI
      |=> sec_rsp.retry == !$past(port_opt_reg[rcm_pkg::OPT_S_WR_ALIAS]);
  endproperty
  a_sec_wr_alias: assert property (p_sec_wr_alias) // RQ6
    else $error("secondary write alias decision wrong");

  property p_pri_lm_alias;
    @(posedge mclk) disable iff (reset)
      pri_cmp.valid && pri_cmp.addr_hit &&
      pri_cmp.queued_cmd == rcm_pkg::CMD_MEM_RDM &&
      pri_cmp.retry_cmd == rcm_pkg::CMD_MEM_RDL
      |=> pri_rsp.done == $past(port_opt_reg[rcm_pkg::OPT_P_LM_ALIAS]);
  endproperty
  a_pri_lm_alias: assert property (p_pri_lm_alias) // RQ7
    else $error("primary line/multiple alias wrong");

  property p_sec_lm_alias;
    @(posedge mclk) disable iff (reset)
      sec_cmp.valid && sec_cmp.addr_hit &&
      sec_cmp.queued_cmd == rcm_pkg::CMD_MEM_RDL &&
      sec_cmp.retry_cmd == rcm_pkg::CMD_MEM_RDM
      |=> sec_rsp.done == $past(port_opt_reg[rcm_pkg::OPT_S_LM_ALIAS]);
  endproperty
  a_sec_lm_alias: assert property (p_sec_lm_alias) // RQ8
    else $error("secondary line/multiple alias wrong");

  property p_wri_convert;
    @(posedge mclk) disable iff (reset)
      !port_opt_reg[rcm_pkg::OPT_P_WRI_DISC] &&
      pri_fwd_in_cmd == rcm_pkg::CMD_MEM_WRI
      |=> pri_fwd_out_cmd == rcm_pkg::CMD_MEM_WR;
  endproperty
  a_wri_convert: assert property (p_wri_convert) // RQ9
    else $error("write-invalidate not converted");

  property p_one_answer;
    @(posedge mclk) disable iff (reset)
      pri_cmp.valid |=> (pri_rsp.done ^ pri_rsp.retry) ##1
      !(pri_rsp.done || pri_rsp.retry) || $past(pri_cmp.valid);
  endproperty
  a_one_answer: assert property (p_one_answer) // RQ10
    else $error("compare gave no single answer");

endmodule

`default_nettype wire

/* verif/rcm_initiator_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// retrying pci initiator, one per bus side
// ****************************************
module rcm_initiator_model (
  input  wire logic              mclk,
  output var  rcm_pkg::rcm_cmp_s cmp,
  input  wire rcm_pkg::rcm_rsp_s rsp
);

  initial cmp = '0;

  // gap lets the initiator come back late as well as at once
  task automatic issue(input logic [3:0] rc, input logic [3:0] qc,
                       input logic hit, input logic [1:0] gap,
                       output logic [1:0] got);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    cmp <= '{valid: 1'b1, retry_cmd: rc, queued_cmd: qc, addr_hit: hit};
    @(posedge mclk);
    // released lines show the inverse, not a stale copy
    cmp <= '{valid: 1'b0, retry_cmd: ~rc, queued_cmd: ~qc, addr_hit: ~hit};
    @(posedge mclk);
    got = {rsp.done, rsp.retry};
  endtask

endmodule
`default_nettype wire

/* verif/test_retry_command_match_control.sv */
`timescale 1ns/100ps
`default_nettype none

module test_retry_command_match_control;

  // ****************************************
  // stimulus and wiring
  // ****************************************
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic              s_axi_awvalid = 1'b0;
  logic              s_axi_awready;
  logic [31:0]       s_axi_wdata = 32'h0000_0000;
  logic [3:0]        s_axi_wstrb = 4'h0;
  logic              s_axi_wvalid = 1'b0;
  logic              s_axi_wready;
  logic [1:0]        s_axi_bresp;
  logic              s_axi_bvalid;
  logic              s_axi_bready = 1'b0;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic              s_axi_arvalid = 1'b0;
  logic              s_axi_arready;
  logic [31:0]       s_axi_rdata;
  logic [1:0]        s_axi_rresp;
  logic              s_axi_rvalid;
  logic              s_axi_rready = 1'b0;
  rcm_pkg::rcm_cmp_s pri_cmp;
  rcm_pkg::rcm_cmp_s sec_cmp;
  rcm_pkg::rcm_rsp_s pri_rsp;
  rcm_pkg::rcm_rsp_s sec_rsp;
  logic              master_timeout = 1'b0;
  logic [3:0]        pri_fwd_in_cmd = 4'h0;
  logic [3:0]        pri_fwd_out_cmd;
  logic              pri_wri_disconnect;
  logic              primary_system_error_n;
  logic              irq;
  int                err_total = 0;
  int                compares = 0;
  logic [3:0]        cmd_tab [5] = '{rcm_pkg::CMD_MEM_RD, rcm_pkg::CMD_MEM_WR,
                       rcm_pkg::CMD_MEM_RDM, rcm_pkg::CMD_MEM_RDL,
                       rcm_pkg::CMD_MEM_WRI};

  always #5 mclk = ~mclk;

  rcm_match_ctrl i_dut (
    .mclk(mclk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .pri_cmp(pri_cmp), .sec_cmp(sec_cmp),
    .pri_rsp(pri_rsp), .sec_rsp(sec_rsp), .master_timeout(master_timeout),
    .pri_fwd_in_cmd(pri_fwd_in_cmd), .pri_fwd_out_cmd(pri_fwd_out_cmd),
    .pri_wri_disconnect(pri_wri_disconnect),
    .primary_system_error_n(primary_system_error_n), .irq(irq)
  );

  rcm_initiator_model i_pri (.mclk(mclk), .cmp(pri_cmp), .rsp(pri_rsp));
  rcm_initiator_model i_sec (.mclk(mclk), .cmp(sec_cmp), .rsp(sec_rsp));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge mclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic exp_match(input logic sec, input logic [15:0] o,
                                     input logic [3:0] r, input logic [3:0] q,
                                     input logic h);
    logic rd_a, wr_a, lm_a, rml, qml;
    rd_a = sec ? o[3] : o[1];
    wr_a = sec ? o[4] : o[2];
    lm_a = sec ? o[6] : o[5];
    rml = (r == rcm_pkg::CMD_MEM_RDM) || (r == rcm_pkg::CMD_MEM_RDL);
    qml = (q == rcm_pkg::CMD_MEM_RDM) || (q == rcm_pkg::CMD_MEM_RDL);
    return h && ((r == q) || (rd_a && rml && q == rcm_pkg::CMD_MEM_RD) ||
           (wr_a && r == rcm_pkg::CMD_MEM_WRI && q == rcm_pkg::CMD_MEM_WR) ||
           (lm_a && rml && qml));
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic reg_check();
    logic [31:0] d;
    logic [1:0]  r;
    check("serr at reset", 32'h0000_0001, 32'(primary_system_error_n));
    check("irq at reset", 32'h0000_0000, 32'(irq));
    axi_read(rcm_pkg::OFS_PORT_OPT, d, r);
    check("option reset", 32'h0000_0C6A, d);
    check("read resp", 32'(rcm_pkg::RESP_OKAY), 32'(r));
    axi_write(rcm_pkg::OFS_PORT_OPT, 32'hFFFF_FFFF, r);
    check("write resp", 32'(rcm_pkg::RESP_OKAY), 32'(r));
    axi_read(rcm_pkg::OFS_PORT_OPT, d, r);
    check("option all ones", 32'h0000_0FFE, d);
    axi_read(rcm_pkg::OFS_STATUS, d, r);
    check("status reset", 32'h0000_0000, d);
    axi_read(8'h40, d, r);
    check("unmapped read", {30'h0, rcm_pkg::RESP_DECERR}, {30'h0, r});
    axi_write(8'h40, 32'h0000_0001, r);
    check("unmapped write", {30'h0, rcm_pkg::RESP_DECERR}, {30'h0, r});
  endtask

  // every retry and queued command pair, both sides, varied spacing
  task automatic match_sweep(input logic [15:0] o);
    logic [1:0] got;
    logic [1:0] r;
    logic       m;
    axi_write(rcm_pkg::OFS_PORT_OPT, {16'h0000, o}, r);
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 5; i++) begin
        for (int j = 0; j < 5; j++) begin
          m = exp_match(s[0], o, cmd_tab[i], cmd_tab[j], 1'b1);
          if (s == 0) i_pri.issue(cmd_tab[i], cmd_tab[j], 1'b1, j[1:0], got);
          else i_sec.issue(cmd_tab[i], cmd_tab[j], 1'b1, j[1:0], got);
          check("match answer", {30'h0, m, !m}, {30'h0, got});
        end
      end
    end
    i_sec.issue(cmd_tab[0], cmd_tab[0], 1'b0, 2'h0, got);
    check("address miss", 32'h0000_0001, {30'h0, got});
  endtask

  task automatic fwd_check();
    logic [1:0] r;
    axi_write(rcm_pkg::OFS_PORT_OPT, 32'h0000_0000, r);
    pri_fwd_in_cmd <= rcm_pkg::CMD_MEM_WRI;
    repeat (2) @(posedge mclk);
    check("cvt cmd", 32'(rcm_pkg::CMD_MEM_WR), 32'(pri_fwd_out_cmd));
    check("no disconnect", 32'h0000_0000, {31'h0, pri_wri_disconnect});
    pri_fwd_in_cmd <= rcm_pkg::CMD_MEM_RDL;
    repeat (2) @(posedge mclk);
    check("pass cmd", 32'(rcm_pkg::CMD_MEM_RDL), 32'(pri_fwd_out_cmd));
    axi_write(rcm_pkg::OFS_PORT_OPT, 32'h0000_0080, r);
    pri_fwd_in_cmd <= rcm_pkg::CMD_MEM_WRI;
    repeat (2) @(posedge mclk);
    check("kept cmd", 32'(rcm_pkg::CMD_MEM_WRI), 32'(pri_fwd_out_cmd));
    check("disconnect", 32'h0000_0001, {31'h0, pri_wri_disconnect});
  endtask

  // raise, mask and clear the timeout flag
  task automatic tmo_check(input logic [31:0] msk);
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(rcm_pkg::OFS_MASK, msk, r);
    axi_read(rcm_pkg::OFS_MASK, d, r);
    check("mask", msk & rcm_pkg::STS_WMASK, d);
    @(posedge mclk);
    master_timeout <= 1'b1;
    @(posedge mclk);
    master_timeout <= 1'b0;
    repeat (2) @(posedge mclk);
    check("serr low", 32'h0000_0000, {31'h0, primary_system_error_n});
    check("irq set", {31'h0, msk[23]}, {31'h0, irq});
    axi_read(rcm_pkg::OFS_STATUS, d, r);
    check("status set", 32'h0080_0000, d);
    axi_write(rcm_pkg::OFS_STATUS, 32'h0080_0000, r);
    axi_read(rcm_pkg::OFS_STATUS, d, r);
    check("status cleared", 32'h0000_0000, d);
    repeat (2) @(posedge mclk);
    check("serr released", 32'h0000_0001, {31'h0, primary_system_error_n});
    check("irq clear", 32'h0000_0000, {31'h0, irq});
  endtask

  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    reg_check();
    match_sweep(16'h0000);
    match_sweep(16'h002A);
    match_sweep(16'h0054);
    match_sweep(16'h007E);
    fwd_check();
    tmo_check(32'h0080_0000);
    tmo_check(32'h0000_0000);
    wrap_up();
  end

  // a hang counts as a mismatch; the run needs about 1000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    wrap_up();
  end

endmodule
`default_nettype wire
